//--- cor_contact_output_router.sv
// Contact output router: Avalon-MM registers, alarm classing, three contacts
//
// Operation
// - Three contact outputs, each with own source, polarity and alarm number.
// - Contacts follow their source continuously as levels, never pulses.
// - Polarity picks normally open or normally closed, inverting the condition.
// - Halting-alarm source closes the contact while a halting alarm is active.
// - Continuing-alarm source closes the contact while a continuing alarm is active.
// - Any-alarm source closes while an alarm of either class is active.
// - Temperature-ready source closes while the fluid temperature is ready.
// - Passthrough with normally open copies contact input one or two unchanged.
// - Passthrough with normally closed gives the inverted contact input level.
// - Chosen-alarm source closes only while the numbered alarm is active.
// - Halting alarms stop operation; continuing alarms leave operation running.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module cor_contact_output_router
  import cor_pkg::*;
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,

  // Avalon-MM slave
  input  wire logic [cor_pkg::AddrW-1:0]     avsAddress,
  input  wire logic                          avsRead,
  input  wire logic                          avsWrite,
  input  wire logic [cor_pkg::DataW-1:0]     avsWritedata,
  input  wire logic [3:0]                    avsByteenable,
  output logic [cor_pkg::DataW-1:0]          avsReaddata,
  output logic [1:0]                         avsResponse,
  output logic                               avsWaitrequest,

  // Machine state from core logic
  input  wire logic                          runRequest,
  input  wire logic                          remoteMode,
  input  wire logic                          tempReady,
  input  wire logic                          antifreezeEnabled,
  input  wire logic [cor_pkg::AlarmCount-1:0] alarmActive,

  // Contact input pins
  input  wire logic                          contactInOne,
  input  wire logic                          contactInTwo,

  // Contact outputs, 1 = closed
  output logic [cor_pkg::NumOutputs-1:0]     contactClosed,
  output logic                               operationEnable
);

  // Avalon response codes
  localparam logic [1:0] RespOkay   = 2'h0;
  localparam logic [1:0] RespDecErr = 2'h3;

  // Configuration registers
  corSrc_t                sourceQ     [NumOutputs];
  logic [NumOutputs-1:0]  polarityQ;
  logic [AlarmNumW-1:0]   alarmNumQ   [NumOutputs];
  logic [DataW-1:0]       haltClassQ  [ClassWords];

  // Synchronised contact inputs
  logic inputOneSync;
  logic inputTwoSync;

  // Alarm classing
  logic [AlarmCount-1:0]  haltMask;
  logic                   haltingAlarm;
  logic                   continuingAlarm;
  logic                   operating;

  // Per-output next contact level
  logic [NumOutputs-1:0]  closedNext;

  // Bus decode
  logic                   accessNow;
  logic                   writeNow;
  logic [DataW-1:0]       byteMask;
  logic [DataW-1:0]       readMux;
  logic                   addrHit;
  logic [DataW-1:0]       statusWord;
  logic [DataW-1:0]       cfgWord     [NumOutputs];

  // Pin inputs cross into core_clk first
  cor_sync2 uSyncOne (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (contactInOne),
    .syncOut  (inputOneSync)
  );

  cor_sync2 uSyncTwo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (contactInTwo),
    .syncOut  (inputTwoSync)
  );

  // Flatten class words into one mask
  genvar w;
  generate
    for (w = 0; w < ClassWords; w++) begin : gClassMask
      assign haltMask[w*DataW +: DataW] = haltClassQ[w];
    end
  endgenerate

  assign haltingAlarm    = |(alarmActive & haltMask);
  assign continuingAlarm = |(alarmActive & ~haltMask);

  assign operating = runRequest & ~haltingAlarm;

  // Byte lane mask from byteenable
  always_comb begin
    byteMask = '0;
    for (int b = 0; b < 4; b++) begin
      byteMask[b*8 +: 8] = {8{avsByteenable[b]}};
    end
  end

  // Request accepted on the edge where waitrequest is low
  assign accessNow = (avsRead | avsWrite) & ~avsWaitrequest;
  assign writeNow  = accessNow & avsWrite;

  // Readable configuration words
  genvar c;
  generate
    for (c = 0; c < NumOutputs; c++) begin : gCfgWord
      always_comb begin
        cfgWord[c] = '0;
        cfgWord[c][CfgSrcLsb +: SrcW]      = sourceQ[c];
        cfgWord[c][CfgPolBit]              = polarityQ[c];
        cfgWord[c][CfgAlmLsb +: AlarmNumW] = alarmNumQ[c];
      end
    end
  endgenerate

  // Status shows live block state
  always_comb begin
    statusWord = '0;
    statusWord[StsContactLsb +: NumOutputs] = contactClosed;
    statusWord[StsInputLsb]                 = inputOneSync;
    statusWord[StsInputLsb + 1]             = inputTwoSync;
    statusWord[StsHaltBit]                  = haltingAlarm;
    statusWord[StsContBit]                  = continuingAlarm;
    statusWord[StsOperBit]                  = operationEnable;
  end

  // Read decode; unmapped reads give zero
  always_comb begin
    readMux = '0;
    addrHit = 1'b1;
    if (avsAddress == OfsOutCfg0) begin
      readMux = cfgWord[0];
    end else if (avsAddress == OfsOutCfg1) begin
      readMux = cfgWord[1];
    end else if (avsAddress == OfsOutCfg2) begin
      readMux = cfgWord[2];
    end else if (avsAddress == OfsStatus) begin
      readMux = statusWord;
    end else if ((avsAddress >= OfsHaltClass0) && (avsAddress <= OfsHaltClass3)
                 && (avsAddress[1:0] == 2'h0)) begin
      readMux = haltClassQ[avsAddress[3:2]];
    end else begin
      addrHit = 1'b0;
    end
  end

  // One wait cycle, then a single ready cycle per request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsWaitrequest <= 1'b1;
    end else begin
      avsWaitrequest <= ~((avsRead | avsWrite) & avsWaitrequest);
    end
  end

  // Read data and response captured while waiting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsReaddata <= '0;
      avsResponse <= RespOkay;
    end else if ((avsRead | avsWrite) & avsWaitrequest) begin
      avsReaddata <= avsRead ? readMux : '0;
      avsResponse <= addrHit ? RespOkay : RespDecErr;
    end
  end

  generate
    for (c = 0; c < NumOutputs; c++) begin : gCfgReg
      localparam logic [AddrW-1:0] CfgOfs = AddrW'(OfsOutCfg0 + 4 * c);
      localparam corSrc_t RstSrc = (c == 0) ? RstSrcOut1 :
                                   (c == 1) ? RstSrcOut2 : RstSrcOut3;
      logic [DataW-1:0] merged;

      assign merged = (cfgWord[c] & ~byteMask) | (avsWritedata & byteMask);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sourceQ[c]   <= RstSrc;
          polarityQ[c] <= RstPolarity[c];
          alarmNumQ[c] <= RstAlarmNum;
        end else if (writeNow && (avsAddress == CfgOfs)) begin
          sourceQ[c]   <= corSrc_t'(merged[CfgSrcLsb +: SrcW]);
          polarityQ[c] <= merged[CfgPolBit];
          alarmNumQ[c] <= merged[CfgAlmLsb +: AlarmNumW];
        end
      end
    end
  endgenerate

  // Alarm class words; a set bit makes that alarm halting
  generate
    for (w = 0; w < ClassWords; w++) begin : gClassReg
      localparam logic [AddrW-1:0] ClsOfs = AddrW'(OfsHaltClass0 + 4 * w);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          haltClassQ[w] <= RstHaltClass;
        end else if (writeNow && (avsAddress == ClsOfs)) begin
          haltClassQ[w] <= (haltClassQ[w] & ~byteMask) | (avsWritedata & byteMask);
        end
      end
    end
  endgenerate

  generate
    for (c = 0; c < NumOutputs; c++) begin : gSelect
      cor_source_select uSel (
        .source            (sourceQ[c]),
        .normallyClosed    (polarityQ[c]),
        .alarmNum          (alarmNumQ[c]),
        .operating         (operating),
        .remoteMode        (remoteMode),
        .haltingAlarm      (haltingAlarm),
        .continuingAlarm   (continuingAlarm),
        .tempReady         (tempReady),
        .antifreezeEnabled (antifreezeEnabled),
        .inputOne          (inputOneSync),
        .inputTwo          (inputTwoSync),
        .alarmActive       (alarmActive),
        .closedNext        (closedNext[c])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      contactClosed <= '0;
    end else begin
      contactClosed <= closedNext;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      operationEnable <= 1'b0;
    end else begin
      operationEnable <= operating;
    end
  end

endmodule // cor_contact_output_router

//--- cor_pkg.sv
// Shared constants and types for the contact output router
package cor_pkg;

  // Sizes
  localparam int NumOutputs = 3;
  localparam int AlarmCount = 128;
  localparam int AlarmNumW  = 7;
  localparam int SrcW       = 4;
  localparam int DataW      = 32;
  localparam int AddrW      = 6;
  localparam int ClassWords = AlarmCount / DataW;

  // Contact source selections
  typedef enum logic [SrcW-1:0] {
    CorSrcDisabled,
    CorSrcOperation,
    CorSrcRemoteModeSource,
    CorSrcHaltingAlarmSource,
    CorSrcContinuingAlarmSource,
    CorSrcAnyAlarmSource,
    CorSrcTempReady,
    CorSrcAntifreezeEnabledSource,
    CorSrcInputOnePassthrough,
    CorSrcInputTwoPassthrough,
    CorSrcChosenAlarm
  } corSrc_t;

  // Register byte offsets
  localparam logic [AddrW-1:0] OfsOutCfg0    = 6'h00;
  localparam logic [AddrW-1:0] OfsOutCfg1    = 6'h04;
  localparam logic [AddrW-1:0] OfsOutCfg2    = 6'h08;
  localparam logic [AddrW-1:0] OfsStatus     = 6'h0c;
  localparam logic [AddrW-1:0] OfsHaltClass0 = 6'h10;
  localparam logic [AddrW-1:0] OfsHaltClass3 = 6'h1c;

  // Output configuration field positions
  localparam int CfgSrcLsb = 0;
  localparam int CfgPolBit = 4;
  localparam int CfgAlmLsb = 8;

  // Status field positions
  localparam int StsContactLsb = 0;
  localparam int StsInputLsb   = 3;
  localparam int StsHaltBit    = 5;
  localparam int StsContBit    = 6;
  localparam int StsOperBit    = 7;

  // Reset values
  localparam corSrc_t RstSrcOut1 = CorSrcOperation;
  localparam corSrc_t RstSrcOut2 = CorSrcAnyAlarmSource;
  localparam corSrc_t RstSrcOut3 = CorSrcTempReady;
  localparam logic [NumOutputs-1:0] RstPolarity = 3'h2;
  localparam logic [AlarmNumW-1:0]  RstAlarmNum = 7'h01;
  localparam logic [DataW-1:0]      RstHaltClass = 32'h00000000;

endpackage

//--- cor_sync2.sv
// Two-stage synchroniser for contact input pins
`timescale 1ns/1ns
module cor_sync2 (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic metaQ;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      metaQ   <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      metaQ   <= asyncIn;
      syncOut <= metaQ;
    end
  end

endmodule // cor_sync2

//--- cor_source_select.sv
// Per-output source selection and polarity for one contact
`timescale 1ns/1ns
module cor_source_select
  import cor_pkg::*;
(
  // Configuration
  input  wire cor_pkg::corSrc_t             source,
  input  wire logic                         normallyClosed,
  input  wire logic [cor_pkg::AlarmNumW-1:0] alarmNum,
  // Machine conditions
  input  wire logic                         operating,
  input  wire logic                         remoteMode,
  input  wire logic                         haltingAlarm,
  input  wire logic                         continuingAlarm,
  input  wire logic                         tempReady,
  input  wire logic                         antifreezeEnabled,
  input  wire logic                         inputOne,
  input  wire logic                         inputTwo,
  input  wire logic [cor_pkg::AlarmCount-1:0] alarmActive,
  // Contact level, 1 = closed
  output logic                              closedNext
);

  logic cond;

  always_comb begin
    cond = 1'b0;
    case (source)
      CorSrcOperation:               cond = operating;
      CorSrcRemoteModeSource:        cond = remoteMode;
      CorSrcAntifreezeEnabledSource: cond = antifreezeEnabled;
      CorSrcHaltingAlarmSource:      cond = haltingAlarm;
      CorSrcContinuingAlarmSource:   cond = continuingAlarm;
      CorSrcAnyAlarmSource:          cond = haltingAlarm | continuingAlarm;
      CorSrcTempReady:               cond = tempReady;
      CorSrcInputOnePassthrough:     cond = inputOne;
      CorSrcInputTwoPassthrough:     cond = inputTwo;
      CorSrcChosenAlarm:             cond = alarmActive[alarmNum];
      default:                       cond = 1'b0;
    endcase
  end

  always_comb begin
    if ((source == CorSrcDisabled) || (source > CorSrcChosenAlarm)) begin
      closedNext = 1'b0;
    end else begin
      closedNext = cond ^ normallyClosed;
    end
  end

endmodule // cor_source_select

//--- cor_router_asserts.sv
// Port-level assertion checker for the contact output router
`timescale 1ns/1ns
module cor_router_asserts
  import cor_pkg::*;
(
  // Clock and reset
  input wire logic                           core_clk,
  input wire logic                           rst_n,
  // Register bus
  input wire logic [cor_pkg::AddrW-1:0]      avsAddress,
  input wire logic                           avsRead,
  input wire logic                           avsWrite,
  input wire logic [cor_pkg::DataW-1:0]      avsReaddata,
  input wire logic [1:0]                     avsResponse,
  input wire logic                           avsWaitrequest,
  // Machine state and pins
  input wire logic                           runRequest,
  input wire logic                           remoteMode,
  input wire logic                           tempReady,
  input wire logic                           antifreezeEnabled,
  input wire logic [cor_pkg::AlarmCount-1:0] alarmActive,
  input wire logic                           contactInOne,
  input wire logic                           contactInTwo,
  // Contacts
  input wire logic [cor_pkg::NumOutputs-1:0] contactClosed,
  input wire logic                           operationEnable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wire logic  anyReq = avsRead | avsWrite;
  logic [2:0] quietQ;

  // Cycles without any cause that may move a contact; pins need three edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) quietQ <= 3'h0;
    else if (avsWrite || $changed({runRequest, remoteMode, tempReady, antifreezeEnabled,
        alarmActive, contactInOne, contactInTwo})) quietQ <= 3'h0;
    else if (quietQ != 3'h7) quietQ <= quietQ + 3'h1;
  end

  sequence sTaken;
    anyReq && avsWaitrequest;
  endsequence
  sequence sOneWait;
    !avsWaitrequest ##1 avsWaitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (sTaken |=> sOneWait)
    else $error("bus answer not after exactly one wait cycle");
  AST_BUS_IDLE: assert property (!anyReq |=> avsWaitrequest)
    else $error("waitrequest low without a request");
  AST_UNMAPPED: assert property (anyReq && !avsWaitrequest && avsAddress > OfsHaltClass3
    |-> avsResponse == 2'h3 && (avsWrite || avsReaddata == '0))
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (anyReq && !avsWaitrequest && avsAddress <= OfsHaltClass3
    && avsAddress[1:0] == 2'h0 && (avsAddress < 6'h0d || avsAddress >= OfsHaltClass0)
    |-> avsResponse == 2'h0)
    else $error("mapped access refused");
  AST_NO_RUN: assert property (!runRequest |=> !operationEnable)
    else $error("operation enabled without run request");
  AST_CLEAN_RUN: assert property (runRequest && alarmActive == '0 |=> operationEnable)
    else $error("operation blocked without any alarm");
  AST_LEVEL_HOLD: assert property (quietQ >= 3'h4 |-> $stable(contactClosed))
    else $error("contact moved without a cause");
  AST_NO_ALARM_STS: assert property (quietQ >= 3'h4 && alarmActive == '0 && avsRead
    && !avsWaitrequest && avsAddress == OfsStatus |-> avsReaddata[6:5] == 2'h0)
    else $error("alarm class flagged with no alarm active");
endmodule // cor_router_asserts

bind cor_contact_output_router cor_router_asserts i_chk (.core_clk, .rst_n, .avsAddress,
  .avsRead, .avsWrite, .avsReaddata, .avsResponse, .avsWaitrequest, .runRequest, .remoteMode,
  .tempReady, .antifreezeEnabled, .alarmActive, .contactInOne, .contactInTwo, .contactClosed,
  .operationEnable);

//--- cor_contact_sensor.sv
// Customer equipment model: switches on the inputs, sensing of the contacts
`timescale 1ns/1ns
module cor_contact_sensor (
  // Clock
  input wire logic       core_clk,
  // Contacts from the router, 1 = closed
  input wire logic [2:0] contactClosed,
  // Switch commands and the pins they drive
  input wire logic [1:0] switchCmd,
  output logic           contactInOne,
  output logic           contactInTwo,
  // Sensed contact state
  output logic [2:0]     sensedClosed
);
  // Switch levels are steady, no bounce modelled
  assign contactInOne = switchCmd[0];
  assign contactInTwo = switchCmd[1];
  // Level sensing only, short pulses would be missed
  always_ff @(posedge core_clk) sensedClosed <= contactClosed;
endmodule // cor_contact_sensor

//--- contact_output_router_test.sv
// Self-checking testbench for the contact output router
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module contact_output_router_test;
  import cor_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [AddrW-1:0]      avsAddress = '0;
  logic                  avsRead = 1'b0;
  logic                  avsWrite = 1'b0;
  logic [DataW-1:0]      avsWritedata = '0;
  logic [3:0]            avsByteenable = 4'hf;
  logic [DataW-1:0]      avsReaddata;
  logic [1:0]            avsResponse;
  logic                  avsWaitrequest;
  logic                  runRequest = 1'b0;
  logic                  remoteMode = 1'b0;
  logic                  tempReady = 1'b0;
  logic                  antifreezeEnabled = 1'b0;
  logic [AlarmCount-1:0] alarmActive = '0;
  logic                  contactInOne;
  logic                  contactInTwo;
  logic [NumOutputs-1:0] contactClosed;
  logic                  operationEnable;
  logic [1:0]            switchCmd = 2'h0;
  logic [2:0]            sensedClosed;
  logic [DataW-1:0]      rdData;
  logic [1:0]            rdResp;
  int                    fails = 0;
  int                    check_count = 0;
  // Conditions 0..7 that close each source; 8 is all quiet
  logic [8:0]            hitMask [12] = '{9'h00, 9'h01, 9'h02, 9'h04, 9'h08, 9'h0c,
                                          9'h10, 9'h20, 9'h40, 9'h80, 9'h08, 9'h00};

  always #5 core_clk = ~core_clk;

  cor_contact_output_router i_dut (.core_clk, .rst_n, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable, .avsReaddata, .avsResponse, .avsWaitrequest, .runRequest,
    .remoteMode, .tempReady, .antifreezeEnabled, .alarmActive, .contactInOne, .contactInTwo,
    .contactClosed, .operationEnable);
  cor_contact_sensor i_far (.core_clk, .contactClosed, .switchCmd, .contactInOne,
    .contactInTwo, .sensedClosed);

  task automatic busReq(input logic wr, input logic [AddrW-1:0] a, input logic [DataW-1:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    rdData = avsReaddata;
    rdResp = avsResponse;
    `CHK("waitrequest", 1'b0, avsWaitrequest)
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask

  // Only condition k active, plus run request when run is set; alarm 5 is halting, alarm 9 continuing
  task automatic setCond(input int k, input logic run);
    runRequest <= (k == 0) || run;
    remoteMode <= (k == 1);
    alarmActive <= {{(AlarmCount-10){1'b0}}, k == 3, 3'h0, k == 2, 5'h0};
    tempReady <= (k == 4);
    antifreezeEnabled <= (k == 5);
    switchCmd <= {k == 7, k == 6};
    repeat (5) @(posedge core_clk);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    // Tests need under 2000 cycles; allow ample margin well inside the run budget
    #100000;
    fails++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    busReq(1'b0, OfsOutCfg0, '0);
    `CHK("cfg1", {17'h0, RstAlarmNum, 3'h0, RstPolarity[0], RstSrcOut1}, rdData)
    busReq(1'b0, OfsOutCfg1, '0);
    `CHK("cfg2", {17'h0, RstAlarmNum, 3'h0, RstPolarity[1], RstSrcOut2}, rdData)
    busReq(1'b0, OfsOutCfg2, '0);
    `CHK("cfg3", {17'h0, RstAlarmNum, 3'h0, RstPolarity[2], RstSrcOut3}, rdData)
    `CHK("reset contacts", 3'h2, contactClosed)
    busReq(1'b1, 6'h20, 32'hffffffff);
    for (int a = 32; a < 64; a += 4) begin
      busReq(1'b0, AddrW'(a), '0);
      `CHK("unmapped", {2'h3, 32'h0}, {rdResp, rdData})
    end
    $display("test reset and map done");
    busReq(1'b1, OfsHaltClass0, 32'h20);
    busReq(1'b0, OfsHaltClass0, '0);
    `CHK("halt class", 32'h20, rdData)
    for (int s = 0; s < 12; s++) begin
      for (int p = 0; p < 2; p++) begin
        busReq(1'b1, AddrW'(4 * (s % 3)), {17'h0, 7'h09, 3'h0, p[0], s[3:0]});
        for (int k = 0; k < 9; k++) begin
          setCond(k, 1'b0);
          `CHK("contact", (s == 0 || s > 10) ? 1'b0 : (hitMask[s][k] ^ p[0]), sensedClosed[s % 3])
        end
      end
    end
    $display("test sources done");
    setCond(2, 1'b1);
    `CHK("halted run", 1'b0, operationEnable)
    busReq(1'b0, OfsStatus, '0);
    `CHK("status halt", 3'h1, rdData[7:5])
    setCond(3, 1'b1);
    `CHK("continued run", 1'b1, operationEnable)
    busReq(1'b0, OfsStatus, '0);
    `CHK("status cont", 3'h6, rdData[7:5])
    setCond(8, 1'b0);
    busReq(1'b0, OfsStatus, '0);
    `CHK("status quiet", 3'h0, rdData[7:5])
    $display("test alarm classes done");
    summarize();
  end
endmodule // contact_output_router_test
